//--- rtl/pec_config_bank.sv
// Configuration register bank: PCI header registers, bus-hold timer and EISA slot decode.
`timescale 1ns/1ps
module pec_config_bank (
    input  wire logic          clock,                  // Host bus clock, 25 MHz.
    input  wire logic          rst_n,                  // System reset, active low.
    // Configuration space access.
    input  wire logic          cfg_sel,                // Configuration access request, one cycle.
    input  wire logic          cfg_wr,                 // 1 write, 0 read.
    input  wire logic [7:0]    cfg_addr,               // Byte offset, word aligned.
    input  wire logic [3:0]    cfg_be,                 // Byte enables for writes.
    input  wire logic [31:0]   cfg_wdata,              // Write data.
    output logic      [31:0]   cfg_rdata,              // Read data, registered.
    output logic               cfg_ack,                // Access done, one cycle.
    // EEPROM loader after reset.
    input  wire logic          eeprom_load,            // Loaded words valid, one cycle.
    input  wire logic [15:0]   eeprom_bus_param_word,  // Bus parameter word.
    input  wire logic [31:0]   eeprom_options_word,    // Adapter option default.
    // Window 3 register path.
    input  wire logic          w3_media_wr,            // Media options write strobe.
    input  wire logic          w3_options_wr,          // Adapter options write strobe.
    input  wire logic [31:0]   w3_wdata,               // Window 3 write data.
    // Bus command bit and ROM decode.
    input  wire logic          mem_access_on,          // Memory-space enable of command register.
    input  wire logic          mem_valid,              // Memory access on the bus, one cycle.
    input  wire logic [31:0]   mem_addr,               // Memory address.
    output logic               rom_hit,                // Access falls in the ROM window.
    output logic [15:0]        rom_offset,             // Offset inside the 64 KB window.
    // Bus master pins.
    input  wire logic          frame_n,                // FRAME# pin.
    input  wire logic          gnt_n,                  // GNT# pin.
    output logic               bus_release,            // Master must give up the bus.
    // EISA slot decode.
    input  wire logic          eisa_mode,              // 1 on the EISA variant.
    input  wire logic          slot_ctl_wr,            // Slot control write strobe.
    input  wire logic          slot_ctl_wdata,         // New card enable value.
    input  wire logic          io_valid,               // Slot I/O access, one cycle.
    input  wire logic [11:0]   io_addr,                // Address within the slot space.
    output logic               slot_decode_on,         // Card enable bit.
    output logic               slot_hit,               // Access decoded by the card.
    output logic [2:0]         slot_window,            // Register window index.
    output logic               slot_switchable,        // Hit is in the switchable window.
    output logic [3:0]         slot_reg,               // Register offset within the window.
    // Driver visible copies.
    output logic [7:0]         irq_routing_note,       // Stored interrupt routing byte.
    output logic [15:0]        media_options_view,     // Media options.
    output logic [31:0]        adapter_options_cfg     // Adapter options.
);
    import pec_pkg::*;

    // ========================================================================
    // Register storage
    // ========================================================================
    logic [15:0] bus_param_ff;
    logic [7:0]  hold_limit_ff;
    logic [31:0] port_base_ff;
    logic [31:0] rom_window_ff;
    logic [7:0]  irq_note_ff;
    logic [15:0] media_ff;
    logic [31:0] options_ff;
    logic        card_en_ff;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic        wr_hit;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{cfg_be[i]}};
        end
    end

    assign wr_hit = cfg_sel && cfg_wr;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_param_ff <= BUS_PARAM_RST;
        end else if (eeprom_load) begin
            bus_param_ff <= eeprom_bus_param_word;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_limit_ff <= HOLD_LIMIT_RST;
        end else if (wr_hit && cfg_addr == OFS_HOLD_LAYOUT && cfg_be[1]) begin
            hold_limit_ff <= {cfg_wdata[15:8+HOLD_LSB], 3'b000};
        end
    end

    // Only the base field is stored; the fixed bits are forced on read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_base_ff <= 32'h0000_0000;
        end else if (wr_hit && cfg_addr == OFS_PORT_BASE) begin
            port_base_ff <= ((cfg_wdata & wmask) | (port_base_ff & ~wmask))
                            & {{(32-PORT_BASE_LSB){1'b1}}, 5'b00000};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rom_window_ff <= 32'h0000_0000;
        end else if (wr_hit && cfg_addr == OFS_BOOT_ROM) begin
            rom_window_ff <= ((cfg_wdata & wmask) | (rom_window_ff & ~wmask))
                             & {16'hffff, 15'h0000, 1'b1};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_note_ff <= IRQ_ROUTING_RST;
        end else if (wr_hit && cfg_addr == OFS_IRQ_HINTS && cfg_be[0]) begin
            irq_note_ff <= cfg_wdata[7:0];
        end
    end

    // Configuration space has no write path here; only window 3 changes it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            media_ff <= MEDIA_OPT_RST;
        end else if (w3_media_wr) begin
            media_ff <= w3_wdata[15:0];
        end
    end

    // Window 3 and configuration space share one register, so both views agree.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            options_ff <= ADAPTER_OPT_RST;
        end else if (eeprom_load) begin
            options_ff <= eeprom_options_word;
        end else if (w3_options_wr) begin
            options_ff <= w3_wdata;
        end else if (wr_hit && cfg_addr == OFS_ADAPTER_OPT) begin
            options_ff <= (cfg_wdata & wmask) | (options_ff & ~wmask);
        end
    end

    // ========================================================================
    // Configuration read path
    // ========================================================================
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (cfg_addr)
            OFS_CATEGORY: begin
                rd_word = {bus_param_ff[GENERIC_NET_BIT] ? CATEGORY_OTHER : CATEGORY_ETHERNET, 8'h00};
            end
            OFS_HOLD_LAYOUT: begin
                rd_word = {8'h00, LAYOUT_TYPE_VAL, hold_limit_ff, 8'h00};
            end
            OFS_PORT_BASE: begin
                rd_word = port_base_ff | 32'h0000_0001;
            end
            OFS_BOOT_ROM: begin
                rd_word = rom_window_ff;
            end
            OFS_IRQ_HINTS: begin
                rd_word = {BUS_INTERVAL_VAL, BURST_NEED_VAL, IRQ_PIN_VAL, irq_note_ff};
            end
            OFS_ADAPTER_OPT: begin
                rd_word = options_ff;
            end
            OFS_MEDIA_OPT: begin
                rd_word = {16'h0000, media_ff};
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack   <= 1'b0;
        end else begin
            cfg_ack <= cfg_sel;
            if (cfg_sel && !cfg_wr) begin
                cfg_rdata <= rd_word;
            end
        end
    end

    // ========================================================================
    // Expansion ROM decode
    // ========================================================================
    // A ROM smaller than 64 KB simply sees the low offset bits, so it aliases.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rom_hit    <= 1'b0;
            rom_offset <= 16'h0000;
        end else begin
            rom_hit <= mem_valid && rom_window_ff[ROM_DECODE_BIT] && mem_access_on
                       && mem_addr[31:ROM_BASE_LSB] == rom_window_ff[31:ROM_BASE_LSB];
            rom_offset <= mem_addr[ROM_BASE_LSB-1:0];
        end
    end

    // ========================================================================
    // Bus-hold timer
    // ========================================================================
    // Pins are synchronised first; the count therefore loads on the third clock after FRAME# falls.
    logic       frame_s1_ff;
    logic       frame_s2_ff;
    logic       frame_d_ff;
    logic       gnt_s1_ff;
    logic       gnt_s2_ff;
    logic [7:0] hold_cnt_ff;
    logic       hold_run_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_s1_ff <= 1'b1;
            frame_s2_ff <= 1'b1;
            frame_d_ff  <= 1'b1;
            gnt_s1_ff   <= 1'b1;
            gnt_s2_ff   <= 1'b1;
        end else begin
            frame_s1_ff <= frame_n;
            frame_s2_ff <= frame_s1_ff;
            frame_d_ff  <= frame_s2_ff;
            gnt_s1_ff   <= gnt_n;
            gnt_s2_ff   <= gnt_s1_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_ff <= 8'h00;
            hold_run_ff <= 1'b0;
        end else if (frame_d_ff && !frame_s2_ff) begin
            hold_cnt_ff <= hold_limit_ff;
            hold_run_ff <= 1'b1;
        end else if (hold_run_ff && hold_cnt_ff != 8'h00) begin
            hold_cnt_ff <= hold_cnt_ff - 8'h01;
        end else if (frame_s2_ff) begin
            hold_run_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_release <= 1'b0;
        end else begin
            bus_release <= hold_run_ff && hold_cnt_ff == 8'h00 && gnt_s2_ff;
        end
    end

    // ========================================================================
    // EISA slot decode
    // ========================================================================
    // Software sets the enable only after resource setup; no ordering check here.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            card_en_ff <= 1'b0;
        end else if (slot_ctl_wr) begin
            card_en_ff <= slot_ctl_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slot_hit        <= 1'b0;
            slot_window     <= 3'd0;
            slot_switchable <= 1'b0;
            slot_reg        <= 4'h0;
        end else begin
            slot_hit        <= 1'b0;
            slot_switchable <= 1'b0;
            slot_reg        <= io_addr[3:0];
            if (io_valid && eisa_mode) begin
                if (io_addr[11:7] == SLOT_CFG_HI) begin
                    slot_hit    <= 1'b1;
                    slot_window <= io_addr[6:4];
                end else if (card_en_ff && io_addr[11:4] == {SLOT_LOW_HI[7:4], SLOT_SW_WIN}) begin
                    slot_hit        <= 1'b1;
                    slot_switchable <= 1'b1;
                end else if (card_en_ff && io_addr[11:4] == {SLOT_LOW_HI[7:4], SLOT_FIX_WIN}) begin
                    slot_hit    <= 1'b1;
                    slot_window <= FIXED_WIN_IDX;
                end
            end
        end
    end

    // ========================================================================
    // Driver visible outputs
    // ========================================================================
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slot_decode_on      <= 1'b0;
            irq_routing_note    <= IRQ_ROUTING_RST;
            media_options_view  <= MEDIA_OPT_RST;
            adapter_options_cfg <= ADAPTER_OPT_RST;
        end else begin
            slot_decode_on      <= card_en_ff;
            irq_routing_note    <= irq_note_ff;
            media_options_view  <= media_ff;
            adapter_options_cfg <= options_ff;
        end
    end

endmodule // pec_config_bank

//--- shared/pec_pkg.sv
// Constants for the configuration register bank of the network adapter.
package pec_pkg;

    // ========================================================================
    // Configuration space byte offsets
    // ========================================================================
    localparam logic [7:0]  OFS_CATEGORY      = 8'h08;
    localparam logic [7:0]  OFS_HOLD_LAYOUT   = 8'h0c;
    localparam logic [7:0]  OFS_PORT_BASE     = 8'h10;
    localparam logic [7:0]  OFS_BOOT_ROM      = 8'h30;
    localparam logic [7:0]  OFS_IRQ_HINTS     = 8'h3c;
    localparam logic [7:0]  OFS_ADAPTER_OPT   = 8'h40;
    localparam logic [7:0]  OFS_MEDIA_OPT     = 8'h48;

    // ========================================================================
    // Fixed read values
    // ========================================================================
    localparam logic [23:0] CATEGORY_ETHERNET = 24'h020000;
    localparam logic [23:0] CATEGORY_OTHER    = 24'h028000;
    localparam logic [7:0]  LAYOUT_TYPE_VAL   = 8'h00;
    localparam logic [7:0]  IRQ_PIN_VAL       = 8'h01;
    localparam logic [7:0]  BURST_NEED_VAL    = 8'h03;
    localparam logic [7:0]  BUS_INTERVAL_VAL  = 8'h08;

    // ========================================================================
    // Field positions and reset values
    // ========================================================================
    localparam int          GENERIC_NET_BIT   = 0;
    localparam int          HOLD_LSB          = 3;
    localparam int          PORT_BASE_LSB     = 5;
    localparam int          ROM_BASE_LSB      = 16;
    localparam int          ROM_DECODE_BIT    = 0;
    localparam int          IO_SPACE_BIT      = 0;
    localparam logic [7:0]  HOLD_LIMIT_RST    = 8'h00;
    localparam logic [7:0]  IRQ_ROUTING_RST   = 8'hff;
    localparam logic [15:0] MEDIA_OPT_RST     = 16'h0000;
    localparam logic [31:0] ADAPTER_OPT_RST   = 32'h0000_0000;
    localparam logic [15:0] BUS_PARAM_RST     = 16'h0000;

    // ========================================================================
    // Slot-specific I/O decode (address bits 11:0 within the slot)
    // ========================================================================
    localparam logic [4:0]  SLOT_CFG_HI       = 5'b11001;
    localparam logic [7:0]  SLOT_LOW_HI       = 8'h00;
    localparam logic [3:0]  SLOT_SW_WIN       = 4'h0;
    localparam logic [3:0]  SLOT_FIX_WIN      = 4'h1;
    localparam logic [2:0]  FIXED_WIN_IDX     = 3'd1;

endpackage : pec_pkg

//--- test/pec_bank_monitor.sv
// Port checker for the configuration register bank.
`timescale 1ns/1ps
module pec_bank_monitor
    import pec_pkg::*;
(
    input wire logic        clock,           // Bus clock.
    input wire logic        rst_n,           // Reset.
    input wire logic        cfg_sel,         // Request.
    input wire logic        cfg_wr,          // Write.
    input wire logic [7:0]  cfg_addr,        // Offset.
    input wire logic [31:0] cfg_rdata,       // Read data.
    input wire logic        cfg_ack,         // Done.
    input wire logic        mem_access_on,   // Memory enable.
    input wire logic        mem_valid,       // Memory access.
    input wire logic        rom_hit,         // ROM hit.
    input wire logic        gnt_n,           // Grant pin.
    input wire logic        bus_release,     // Release.
    input wire logic        eisa_mode,       // Slot variant.
    input wire logic        slot_ctl_wr,     // Enable strobe.
    input wire logic        io_valid,        // Slot access.
    input wire logic [11:0] io_addr,         // Slot address.
    input wire logic        slot_decode_on,  // Card enable.
    input wire logic        slot_hit,        // Slot hit.
    input wire logic [2:0]  slot_window,     // Window.
    input wire logic        slot_switchable  // Switchable hit.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [2:0] win_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) win_ff <= 3'h0;
        else win_ff <= io_addr[6:4];
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    // Back-to-back requests are legal, so the acknowledge simply mirrors the request one cycle later.
    chk_ack_follows: assert property (cfg_ack == $past(cfg_sel)) else $error("ack timing");
    chk_category_code: assert property (cfg_sel && !cfg_wr && cfg_addr == OFS_CATEGORY |=>
        cfg_rdata[7:0] == 8'h00 && (cfg_rdata[31:8] == CATEGORY_ETHERNET || cfg_rdata[31:8] == CATEGORY_OTHER))
        else $error("bad category");
    chk_hold_layout: assert property (cfg_sel && !cfg_wr && cfg_addr == OFS_HOLD_LAYOUT |=>
        cfg_rdata[31:16] == 16'h0000 && cfg_rdata[10:0] == 11'h000) else $error("bad hold word");
    chk_port_low: assert property (cfg_sel && !cfg_wr && cfg_addr == OFS_PORT_BASE |=>
        cfg_rdata[4:0] == 5'h01) else $error("bad port base low bits");
    chk_hint_bytes: assert property (cfg_sel && !cfg_wr && cfg_addr == OFS_IRQ_HINTS |=>
        cfg_rdata[31:8] == {BUS_INTERVAL_VAL, BURST_NEED_VAL, IRQ_PIN_VAL}) else $error("bad hint bytes");
    chk_rom_gate: assert property (rom_hit |-> $past(mem_valid) && $past(mem_access_on))
        else $error("rom hit without enabled access");
    chk_cfg_window: assert property (io_valid && eisa_mode && io_addr[11:7] == SLOT_CFG_HI |=>
        slot_hit && slot_window == win_ff && !slot_switchable) else $error("bad config window");
    chk_slot_closed: assert property (io_valid && eisa_mode && io_addr[11:5] == 7'h00 && !slot_decode_on
        && !slot_ctl_wr && !$past(slot_ctl_wr) |=> !slot_hit) else $error("closed slot decoded");
    chk_fixed_win: assert property (io_valid && eisa_mode && io_addr[11:4] == 8'h01 && slot_decode_on
        && !slot_ctl_wr && !$past(slot_ctl_wr) |=> slot_hit && slot_window == 3'd1 && !slot_switchable)
        else $error("bad fixed window");
    chk_release_gnt: assert property (bus_release |-> $past(gnt_n, 2) || $past(gnt_n, 3) || $past(gnt_n, 4))
        else $error("release while granted");
endmodule // pec_bank_monitor

bind pec_config_bank pec_bank_monitor i_pec_bank_monitor (.clock(clock), .rst_n(rst_n), .cfg_sel(cfg_sel),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .mem_access_on(mem_access_on),
    .mem_valid(mem_valid), .rom_hit(rom_hit), .gnt_n(gnt_n), .bus_release(bus_release), .eisa_mode(eisa_mode),
    .slot_ctl_wr(slot_ctl_wr), .io_valid(io_valid), .io_addr(io_addr), .slot_decode_on(slot_decode_on),
    .slot_hit(slot_hit), .slot_window(slot_window), .slot_switchable(slot_switchable));

//--- test/pec_host_model.sv
// Host side model: bus arbiter pins and slot setup sequence.
`timescale 1ns/1ps
module pec_host_model (
    input  wire logic clock,          // Bus clock.
    input  wire logic rst_n,          // Reset.
    input  wire logic hold_req,       // Hold a master cycle.
    input  wire logic grant_on,       // Keep the grant.
    input  wire logic setup_go,       // Start slot setup.
    output logic      frame_n,        // FRAME# pin.
    output logic      gnt_n,          // GNT# pin.
    output logic      slot_ctl_wr,    // Enable strobe.
    output logic      slot_ctl_wdata  // Enable value.
);
    logic [1:0] step_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_n <= 1'b1;
            gnt_n   <= 1'b1;
        end else begin
            frame_n <= !hold_req;
            gnt_n   <= !grant_on;
        end
    end

    // The card enable strobe is a single pulse a fixed four clocks after setup_go; no reads or writes come first.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) step_ff <= 2'd0;
        else if (setup_go) step_ff <= 2'd1;
        else if (step_ff != 2'd0) step_ff <= step_ff + 2'd1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) slot_ctl_wr <= 1'b0;
        else slot_ctl_wr <= (step_ff == 2'd3);
    end

    assign slot_ctl_wdata = 1'b1;
endmodule // pec_host_model

//--- test/test_pec_config_bank.sv
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
module test_pec_config_bank;
    import pec_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, cfg_sel = 1'b0, cfg_wr = 1'b0, eeprom_load = 1'b0, io_valid = 1'b0;
    logic        w3_media_wr = 1'b0, w3_options_wr = 1'b0, mem_access_on = 1'b0, mem_valid = 1'b0, eisa_mode = 1'b0;
    logic        hold_req = 1'b0, grant_on = 1'b0, setup_go = 1'b0, cfg_ack, rom_hit, frame_n, gnt_n, bus_release;
    logic        slot_ctl_wr, slot_ctl_wdata, slot_decode_on, slot_hit, slot_switchable;
    logic [7:0]  cfg_addr = 8'h00, irq_routing_note;
    logic [3:0]  cfg_be = 4'hf, slot_reg;
    logic [31:0] cfg_wdata = '0, w3_wdata = '0, mem_addr = '0, eeprom_options_word = '0, cfg_rdata, rd, v;
    logic [31:0] adapter_options_cfg;
    logic [15:0] eeprom_bus_param_word = '0, rom_offset, media_options_view;
    logic [11:0] io_addr = '0;
    logic [2:0]  slot_window;
    int          fail_count = 0, check_count = 0, cyc = 0;

    always #20 clock = ~clock;

    pec_config_bank i_pec_config_bank (.clock(clock), .rst_n(rst_n), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .eeprom_load(eeprom_load), .eeprom_bus_param_word(eeprom_bus_param_word),
        .eeprom_options_word(eeprom_options_word), .w3_media_wr(w3_media_wr), .w3_options_wr(w3_options_wr),
        .w3_wdata(w3_wdata), .mem_access_on(mem_access_on), .mem_valid(mem_valid), .mem_addr(mem_addr),
        .rom_hit(rom_hit), .rom_offset(rom_offset), .frame_n(frame_n), .gnt_n(gnt_n), .bus_release(bus_release),
        .eisa_mode(eisa_mode), .slot_ctl_wr(slot_ctl_wr), .slot_ctl_wdata(slot_ctl_wdata), .io_valid(io_valid),
        .io_addr(io_addr), .slot_decode_on(slot_decode_on), .slot_hit(slot_hit), .slot_window(slot_window),
        .slot_switchable(slot_switchable), .slot_reg(slot_reg), .irq_routing_note(irq_routing_note),
        .media_options_view(media_options_view), .adapter_options_cfg(adapter_options_cfg));
    pec_host_model i_pec_host_model (.clock(clock), .rst_n(rst_n), .hold_req(hold_req), .grant_on(grant_on),
        .setup_go(setup_go), .frame_n(frame_n), .gnt_n(gnt_n), .slot_ctl_wr(slot_ctl_wr),
        .slot_ctl_wdata(slot_ctl_wdata));

    // ========================================================================
    // Checking and bus tasks
    // ========================================================================
    task end_of_test;
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock); #1; cfg_sel = 1'b1; cfg_wr = wr; cfg_addr = a; cfg_wdata = d;
        @(posedge clock); #1; cfg_sel = 1'b0; rd = cfg_rdata;
        chk({31'h0, cfg_ack}, 32'h1);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        cfg(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task mem(input logic [31:0] a, input logic hit);
        @(posedge clock); #1; mem_valid = 1'b1; mem_addr = a;
        @(posedge clock); #1; mem_valid = 1'b0;
        chk({31'h0, rom_hit}, {31'h0, hit});
        chk({16'h0, rom_offset}, {16'h0, a[15:0]});
    endtask
    task io(input logic [11:0] a, input logic hit, input logic [2:0] w, input logic sw);
        @(posedge clock); #1; io_valid = 1'b1; io_addr = a;
        @(posedge clock); #1; io_valid = 1'b0;
        chk({30'h0, slot_hit, slot_switchable}, {30'h0, hit, sw});
        if (hit && !sw) chk({29'h0, slot_window}, {29'h0, w});
    endtask
    function automatic logic [31:0] exp_hold(input logic [31:0] w);
        return {16'h0, w[15:11], 11'h000};
    endfunction
    function automatic logic [31:0] exp_rom(input logic [31:0] w);
        return {w[31:16], 15'h0, w[0]};
    endfunction

    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test;
        end
    end

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        v = $urandom(32'hcb44);
        repeat (5) @(posedge clock);
        #1; rst_n = 1'b1;
        rdchk(OFS_IRQ_HINTS, 32'h080301ff);
        rdchk(OFS_CATEGORY, 32'h02000000);
        rdchk(OFS_HOLD_LAYOUT, 32'h0);
        rdchk(8'h04, 32'h0);
        v = $urandom;
        @(posedge clock); #1; eeprom_load = 1'b1; eeprom_bus_param_word = 16'h0001; eeprom_options_word = v;
        @(posedge clock); #1; eeprom_load = 1'b0;
        rdchk(OFS_CATEGORY, 32'h02800000);
        rdchk(OFS_ADAPTER_OPT, v);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hffff_ffff : $urandom;
            cfg(1'b1, OFS_HOLD_LAYOUT, v);
            rdchk(OFS_HOLD_LAYOUT, exp_hold(v));
            cfg(1'b1, OFS_PORT_BASE, v);
            rdchk(OFS_PORT_BASE, {v[31:5], 5'h01});
            cfg(1'b1, OFS_BOOT_ROM, v);
            rdchk(OFS_BOOT_ROM, exp_rom(v));
            cfg(1'b1, OFS_IRQ_HINTS, v);
            rdchk(OFS_IRQ_HINTS, {24'h080301, v[7:0]});
            chk({24'h0, irq_routing_note}, {24'h0, v[7:0]});
            cfg(1'b1, OFS_MEDIA_OPT, v);
            rdchk(OFS_MEDIA_OPT, 32'h0);
        end
        cfg_be = 4'he;
        cfg(1'b1, OFS_IRQ_HINTS, ~v);
        cfg_be = 4'hf;
        rdchk(OFS_IRQ_HINTS, {24'h080301, v[7:0]});
        v = $urandom;
        @(posedge clock); #1; w3_media_wr = 1'b1; w3_options_wr = 1'b1; w3_wdata = v;
        @(posedge clock); #1; w3_media_wr = 1'b0; w3_options_wr = 1'b0;
        rdchk(OFS_MEDIA_OPT, {16'h0, v[15:0]});
        chk({16'h0, media_options_view}, {16'h0, v[15:0]});
        rdchk(OFS_ADAPTER_OPT, v);
        chk(adapter_options_cfg, v);
        v = $urandom;
        cfg(1'b1, OFS_ADAPTER_OPT, v);
        rdchk(OFS_ADAPTER_OPT, v);
        v = $urandom;
        cfg(1'b1, OFS_BOOT_ROM, {v[31:16], 16'h0001});
        mem({v[31:16], v[15:0]}, 1'b0);
        mem_access_on = 1'b1;
        mem({v[31:16], v[15:0]}, 1'b1);
        mem({~v[31:16], v[15:0]}, 1'b0);
        cfg(1'b1, OFS_BOOT_ROM, {v[31:16], 16'h0000});
        mem({v[31:16], 16'hffff}, 1'b0);
        eisa_mode = 1'b1;
        io(12'h005, 1'b0, 3'd0, 1'b0);
        for (int i = 0; i < 8; i++) io({5'b11001, 3'(i), 4'($urandom)}, 1'b1, 3'(i), 1'b0);
        @(posedge clock); #1; setup_go = 1'b1;
        @(posedge clock); #1; setup_go = 1'b0;
        for (int i = 0; i < 10 && slot_decode_on !== 1'b1; i++) @(posedge clock);
        #1; chk({31'h0, slot_decode_on}, 32'h1);
        io(12'h00a, 1'b1, 3'd0, 1'b1);
        chk({28'h0, slot_reg}, 32'ha);
        io(12'h01b, 1'b1, 3'd1, 1'b0);
        eisa_mode = 1'b0;
        io(12'hc85, 1'b0, 3'd0, 1'b0);
        cfg(1'b1, OFS_HOLD_LAYOUT, 32'h0000_1000);
        grant_on = 1'b1;
        hold_req = 1'b1;
        repeat (30) @(posedge clock);
        #1; chk({31'h0, bus_release}, 32'h0);
        grant_on = 1'b0;
        for (int i = 0; i < 8 && bus_release !== 1'b1; i++) @(posedge clock);
        #1; chk({31'h0, bus_release}, 32'h1);
        hold_req = 1'b0;
        repeat (4) @(posedge clock);
        end_of_test;
    end
endmodule // test_pec_config_bank
